// ---- logic/synth_config_field_decode.sv ----
// register bank and field decode of a fractional-N synthesizer configuration
// assumes an AXI4-Lite master on ref_clk and a same-clock fastlock state input
`timescale 1ns/1ps
`include "synth_cfg_consts.svh"
module synth_config_field_decode #(
    parameter logic [31:0] PART_CODE = 32'h0000_5A5A // arbitrary value
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    input wire logic fastlockEngaged,
    output logic [4:0] pumpCurrent,
    output logic pumpTristate,
    output logic pumpNegative,
    output logic [5:0] bleedSetting,
    output logic refDoublerOn,
    output logic [8:0] refDivRatio,
    output logic [2:0] modulatorOrder,
    output logic integerMode,
    output logic orderReserved,
    output logic [1:0] ditherMode,
    output logic fracShutdown,
    output logic [11:0] fbDivider,
    output logic [21:0] fractionDenominator,
    output logic [5:0] outDivRatio,
    output logic outDivInvalid,
    output logic outDivEnable,
    output logic [2:0] outARoute,
    output logic [2:0] outBRoute,
    output logic [5:0] outALevel,
    output logic [5:0] outBLevel,
    output logic outALevelValid,
    output logic outBLevelValid,
    output logic outAEnable,
    output logic outBEnable,
    output logic [1:0] startCore,
    output logic calStart,
    output logic readbackPartCode
);
    // ----------------------------------------
    // state and helpers
    // ----------------------------------------
    synth_cfg_pkg::cfg_state_s s_q;
    synth_cfg_pkg::cfg_state_s s_d;
    logic [4:0] steadyUnits;
    logic steadyHiZ;
    logic [4:0] fastUnits;
    logic fastHiZ;
    logic [2:0] aRoute;
    logic [2:0] bRoute;
    logic aLevelOk;
    logic bLevelOk;
    logic aOn;
    logic bOn;
    logic wrGo;
    logic freqWr;
    logic freqNewInhibit;
    logic rdGo;

    function automatic logic [31:0] mergeWord(
        input logic [31:0] old,
        input logic [31:0] data,
        input logic [3:0] strb,
        input logic [31:0] mask
    );
        logic [31:0] lanes;
        lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        return ((old & ~lanes) | (data & lanes)) & mask;
    endfunction : mergeWord

    function automatic logic [5:0] divRatio(input logic [4:0] code);
        if (code > `OUT_DIV_LAST)
            return 6'h00;
        return 6'({code, 1'b0}) + 6'h02;
    endfunction : divRatio

    // ----------------------------------------
    // field decoders
    // ----------------------------------------
    pump_gain_decode u_steady_gain (
        .gainCode(s_q.pumpReg[`STEADY_GAIN_LSB +: 5]),
        .unitCount(steadyUnits),
        .highImpedance(steadyHiZ)
    );

    pump_gain_decode u_fast_gain (
        .gainCode(s_q.pumpReg[`FAST_GAIN_LSB +: 5]),
        .unitCount(fastUnits),
        .highImpedance(fastHiZ)
    );

    out_route_decode u_route_a (
        .srcSel(s_q.outReg[`A_SRC_LSB +: 2]),
        .level(s_q.outReg[`A_LEVEL_LSB +: 6]),
        .powerdown(s_q.outReg[`A_PD_BIT]),
        .route(aRoute),
        .levelValid(aLevelOk),
        .enable(aOn)
    );

    out_route_decode u_route_b (
        .srcSel(s_q.outReg[`B_SRC_LSB +: 2]),
        .level(s_q.outReg[`B_LEVEL_LSB +: 6]),
        .powerdown(s_q.outReg[`B_PD_BIT]),
        .route(bRoute),
        .levelValid(bLevelOk),
        .enable(bOn)
    );

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb
    begin
        logic [31:0] newFreq;
        logic mapped;
        newFreq = mergeWord(s_q.freqReg, s_q.wData, s_q.wStrb, `MASK_FREQ);
        mapped = 1'b0;
        s_d = s_q;
        wrGo = s_q.awHeld && s_q.wHeld && !s_q.bValid;
        freqWr = wrGo && (s_q.awAddr == `OFS_FREQ_CTRL);
        freqNewInhibit = newFreq[`CAL_INHIBIT_BIT];
        rdGo = s_q.arReady && arvalid;
        s_d.calStart = s_q.calArm;
        s_d.calArm = 1'b0;
        if (s_q.awReady && awvalid)
        begin
            s_d.awHeld = 1'b1;
            s_d.awAddr = awaddr;
        end
        if (s_q.wReady && wvalid)
        begin
            s_d.wHeld = 1'b1;
            s_d.wData = wdata;
            s_d.wStrb = wstrb;
        end
        if (s_q.bValid && bready)
            s_d.bValid = 1'b0;
        if (wrGo)
        begin
            s_d.awHeld = 1'b0;
            s_d.wHeld = 1'b0;
            s_d.bValid = 1'b1;
            s_d.bResp = `RESP_OKAY;
            // reserved and invalid codes are kept as written
            case (s_q.awAddr)
                `OFS_FREQ_CTRL:
                begin
                    s_d.freqReg = newFreq;
                    s_d.lastInhibited = freqNewInhibit;
                    if (!freqNewInhibit)
                    begin
                        s_d.calArm = 1'b1;
                        s_d.calCount = s_q.calCount + 8'h01;
                    end
                end
                `OFS_DENOM: s_d.denReg = mergeWord(s_q.denReg, s_q.wData, s_q.wStrb, `MASK_DENOM);
                `OFS_PUMP: s_d.pumpReg = mergeWord(s_q.pumpReg, s_q.wData, s_q.wStrb, `MASK_PUMP);
                `OFS_REF: s_d.refReg = mergeWord(s_q.refReg, s_q.wData, s_q.wStrb, `MASK_REF);
                `OFS_OUT: s_d.outReg = mergeWord(s_q.outReg, s_q.wData, s_q.wStrb, `MASK_OUT);
                `OFS_STATUS: s_d.bResp = `RESP_OKAY;
                default: s_d.bResp = `RESP_SLVERR;
            endcase
        end
        if (s_q.rValid && rready)
            s_d.rValid = 1'b0;
        if (rdGo)
        begin
            s_d.rValid = 1'b1;
            s_d.rResp = `RESP_OKAY;
            mapped = 1'b1;
            case (araddr)
                `OFS_FREQ_CTRL: s_d.rData = s_q.freqReg;
                `OFS_DENOM: s_d.rData = s_q.denReg;
                `OFS_PUMP: s_d.rData = s_q.pumpReg;
                `OFS_REF: s_d.rData = s_q.refReg;
                `OFS_OUT: s_d.rData = s_q.outReg;
                `OFS_STATUS: s_d.rData = {23'h0, s_q.lastInhibited, s_q.calCount};
                default:
                begin
                    mapped = 1'b0;
                    s_d.rData = 32'h0000_0000;
                    s_d.rResp = `RESP_SLVERR;
                end
            endcase
            // the select stays writable so software can always switch back
            if (mapped && s_q.freqReg[`READBACK_SEL_BIT])
                s_d.rData = PART_CODE;
        end
        s_d.awReady = !s_d.awHeld && !s_d.bValid;
        s_d.wReady = !s_d.wHeld && !s_d.bValid;
        s_d.arReady = !s_d.rValid;
        // decoded settings trail the stored word by one cycle
        s_d.pumpCurrent = fastlockEngaged ? fastUnits : steadyUnits;
        s_d.pumpTristate = fastlockEngaged ? fastHiZ : steadyHiZ;
        s_d.pumpNegative = s_q.pumpReg[`POLARITY_BIT];
        s_d.refDoublerOn = s_q.refReg[`DOUBLER_BIT];
        if (s_q.refReg[`REF_DIV_LSB +: 8] == 8'h00)
            s_d.refDivRatio = `REF_DIV_ZERO_RATIO;
        else
            s_d.refDivRatio = {1'b0, s_q.refReg[`REF_DIV_LSB +: 8]};
        s_d.integerMode = (s_q.freqReg[`ORDER_LSB +: 3] == 3'h0);
        s_d.orderReserved = s_q.freqReg[`ORDER_LSB + 2];
        s_d.fracShutdown = (s_q.freqReg[`DITHER_LSB +: 2] == 2'h3);
        s_d.outDivRatio = divRatio(s_q.outReg[`OUT_DIV_LSB +: 5]);
        s_d.outDivInvalid = (s_q.outReg[`OUT_DIV_LSB +: 5] > `OUT_DIV_LAST);
        s_d.outDivEnable = (aRoute[1] && aOn) || (bRoute[1] && bOn);
        s_d.outARoute = aRoute;
        s_d.outBRoute = bRoute;
        s_d.outALevelValid = aLevelOk;
        s_d.outBLevelValid = bLevelOk;
        s_d.outAEnable = aOn;
        s_d.outBEnable = bOn;
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            s_q <= '0;
            s_q.freqReg <= `RST_FREQ;
            s_q.denReg <= `RST_DENOM;
            s_q.pumpReg <= `RST_PUMP;
            s_q.refReg <= `RST_REF;
            s_q.outReg <= `RST_OUT;
            s_q.pumpTristate <= 1'b1;
            s_q.pumpNegative <= 1'b1;
            s_q.refDivRatio <= 9'h001;
            s_q.integerMode <= 1'b1;
            s_q.outDivRatio <= 6'h02;
        end
        else
            s_q <= s_d;
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign awready = s_q.awReady;
    assign wready = s_q.wReady;
    assign bvalid = s_q.bValid;
    assign bresp = s_q.bResp;
    assign arready = s_q.arReady;
    assign rvalid = s_q.rValid;
    assign rdata = s_q.rData;
    assign rresp = s_q.rResp;
    assign pumpCurrent = s_q.pumpCurrent;
    assign pumpTristate = s_q.pumpTristate;
    assign pumpNegative = s_q.pumpNegative;
    assign bleedSetting = s_q.pumpReg[`BLEED_LSB +: 6];
    assign refDoublerOn = s_q.refDoublerOn;
    assign refDivRatio = s_q.refDivRatio;
    assign modulatorOrder = s_q.freqReg[`ORDER_LSB +: 3];
    assign integerMode = s_q.integerMode;
    assign orderReserved = s_q.orderReserved;
    assign ditherMode = s_q.freqReg[`DITHER_LSB +: 2];
    assign fracShutdown = s_q.fracShutdown;
    assign fbDivider = s_q.freqReg[`FB_DIV_LSB +: 12];
    assign fractionDenominator = s_q.denReg[21:0];
    assign outDivRatio = s_q.outDivRatio;
    assign outDivInvalid = s_q.outDivInvalid;
    assign outDivEnable = s_q.outDivEnable;
    assign outARoute = s_q.outARoute;
    assign outBRoute = s_q.outBRoute;
    assign outALevel = s_q.outReg[`A_LEVEL_LSB +: 6];
    assign outBLevel = s_q.outReg[`B_LEVEL_LSB +: 6];
    assign outALevelValid = s_q.outALevelValid;
    assign outBLevelValid = s_q.outBLevelValid;
    assign outAEnable = s_q.outAEnable;
    assign outBEnable = s_q.outBEnable;
    assign startCore = s_q.refReg[`START_CORE_LSB +: 2];
    assign calStart = s_q.calStart;
    assign readbackPartCode = s_q.freqReg[`READBACK_SEL_BIT];

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_cal_on_write: assert property (@(posedge ref_clk) disable iff (srst)
        (freqWr && !freqNewInhibit) |-> ##2 calStart)
        else $error("calibration not started after frequency write");
    a_cal_inhibited: assert property (@(posedge ref_clk) disable iff (srst)
        (freqWr && freqNewInhibit) |-> ##2 !calStart)
        else $error("calibration started although inhibited");
    a_cal_cause: assert property (@(posedge ref_clk) disable iff (srst)
        calStart |-> $past(freqWr, 2) && !$past(freqNewInhibit, 2))
        else $error("calibration pulse without a frequency write");
    a_pump_fastlock: assert property (@(posedge ref_clk) disable iff (srst)
        (fastlockEngaged && $stable(s_q.pumpReg)) |=>
        (pumpCurrent == $past(s_q.pumpReg[`FAST_GAIN_LSB +: 5]))
        && (pumpTristate == ($past(s_q.pumpReg[`FAST_GAIN_LSB +: 5]) == 5'h00)))
        else $error("fastlock pump current wrong");
    a_pump_steady: assert property (@(posedge ref_clk) disable iff (srst)
        (!fastlockEngaged && $stable(s_q.pumpReg)) |=>
        (pumpCurrent == $past(s_q.pumpReg[`STEADY_GAIN_LSB +: 5]))
        && (pumpTristate == ($past(s_q.pumpReg[`STEADY_GAIN_LSB +: 5]) == 5'h00)))
        else $error("steady pump current wrong");
    a_ref_div_zero: assert property (@(posedge ref_clk) disable iff (srst)
        ($stable(s_q.refReg) && s_q.refReg[`REF_DIV_LSB +: 8] == 8'h00) |=> refDivRatio == 9'h100)
        else $error("reference divide by 256 missing");
    a_out_div_ratio: assert property (@(posedge ref_clk) disable iff (srst)
        ($stable(s_q.outReg) && s_q.outReg[`OUT_DIV_LSB +: 5] <= `OUT_DIV_LAST) |=>
        (outDivRatio == 6'({$past(s_q.outReg[`OUT_DIV_LSB +: 5]), 1'b0}) + 6'h02)
        && !outDivInvalid)
        else $error("output divide ratio wrong");
    a_div_path_only: assert property (@(posedge ref_clk) disable iff (srst)
        outDivEnable |-> (outARoute == 3'h2 && outAEnable) || (outBRoute == 3'h2 && outBEnable))
        else $error("divider enabled with no divided output");
    a_shutdown_dither: assert property (@(posedge ref_clk) disable iff (srst)
        ##1 (fracShutdown == $past(s_q.freqReg[`DITHER_LSB +: 2] == 2'h3)))
        else $error("fraction shutdown does not follow dither code");
    a_readback_code: assert property (@(posedge ref_clk) disable iff (srst)
        (rdGo && araddr <= `OFS_STATUS && araddr[1:0] == 2'h0 && readbackPartCode) |=>
        rvalid && rdata == PART_CODE)
        else $error("part code not returned");
    a_bresp_hold: assert property (@(posedge ref_clk) disable iff (srst)
        (bvalid && !bready) |=> bvalid && $stable(bresp))
        else $error("write response dropped");
endmodule : synth_config_field_decode

// ---- logic/synth_cfg_consts.svh ----
// constants of the synthesizer configuration field block: offsets, fields, resets
// assumes a 32-bit AXI4-Lite register bus with byte addresses
//
// What this block does
// - fastlock gain: 0 high impedance, n is n units
// - output divider code k (0..19) divides by 2(k+1), codes 20..31 give 0 and are flagged invalid
// - divided path used only when selected
// - source 0 osc, 1 divided, 2 external, 3 reserved
// - output B level 0..47, 48..63 reserved
// - output A level 0..47, 48..63 reserved
// - output B powerdown bit 1 powers it down
// - output A powerdown bit 1 powers it down
// - doubler enable bit doubles reference input
// - polarity 1 negative and reset default
// - steady gain: 0 high impedance, n is n units
// - start core selects calibration core 0..3
// - order 0 integer, 1..3 modulation, 4..7 reserved
// - reference divider n, code 0 divides by 256
// - frequency register write calibrates unless inhibited
// - readback select 1 returns part code
// - dither weak, medium, strong, disabled shuts fraction
`ifndef SYNTH_CFG_CONSTS_SVH
`define SYNTH_CFG_CONSTS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFS_FREQ_CTRL 8'h00
`define OFS_DENOM 8'h04
`define OFS_PUMP 8'h08
`define OFS_REF 8'h0C
`define OFS_OUT 8'h10
`define OFS_STATUS 8'h14

// ----------------------------------------
// field positions
// ----------------------------------------
`define FB_DIV_LSB 0
`define ORDER_LSB 12
`define DITHER_LSB 16
`define CAL_INHIBIT_BIT 20
`define READBACK_SEL_BIT 24
`define STEADY_GAIN_LSB 0
`define FAST_GAIN_LSB 8
`define BLEED_LSB 16
`define POLARITY_BIT 24
`define REF_DIV_LSB 0
`define DOUBLER_BIT 8
`define START_CORE_LSB 16
`define OUT_DIV_LSB 0
`define A_SRC_LSB 8
`define B_SRC_LSB 10
`define A_LEVEL_LSB 16
`define B_LEVEL_LSB 24
`define A_PD_BIT 30
`define B_PD_BIT 31
`define LAST_INHIBIT_BIT 8

// ----------------------------------------
// writable masks and reset values
// ----------------------------------------
`define MASK_FREQ 32'h0113_7FFF
`define MASK_DENOM 32'h003F_FFFF
`define MASK_PUMP 32'h013F_1F1F
`define MASK_REF 32'h0003_01FF
`define MASK_OUT 32'hFF3F_0F1F
`define RST_FREQ 32'h0000_0000
`define RST_DENOM 32'h0000_0000
`define RST_PUMP 32'h0100_0000
`define RST_REF 32'h0000_0001
`define RST_OUT 32'h0000_0000

// ----------------------------------------
// code limits and bus answers
// ----------------------------------------
`define OUT_DIV_LAST 5'h13
`define LEVEL_MAX 6'h2F
`define REF_DIV_ZERO_RATIO 9'h100
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// ---- logic/synth_cfg_pkg.sv ----
// types shared by the configuration field block and its decoders
// assumes the constants header for field widths of the register map
package synth_cfg_pkg;

    typedef enum logic [1:0] {
        SRC_OSC = 2'h0,
        SRC_DIV = 2'h1,
        SRC_EXT = 2'h2,
        SRC_RSVD = 2'h3
    } src_sel_e;

    typedef logic [7:0] addr_t;

    typedef struct packed {
        logic awReady;
        logic wReady;
        logic awHeld;
        addr_t awAddr;
        logic wHeld;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic bValid;
        logic [1:0] bResp;
        logic arReady;
        logic rValid;
        logic [1:0] rResp;
        logic [31:0] rData;
        logic [31:0] freqReg;
        logic [31:0] denReg;
        logic [31:0] pumpReg;
        logic [31:0] refReg;
        logic [31:0] outReg;
        logic [7:0] calCount;
        logic lastInhibited;
        logic calArm;
        logic calStart;
        logic [4:0] pumpCurrent;
        logic pumpTristate;
        logic pumpNegative;
        logic refDoublerOn;
        logic [8:0] refDivRatio;
        logic integerMode;
        logic orderReserved;
        logic fracShutdown;
        logic [5:0] outDivRatio;
        logic outDivInvalid;
        logic outDivEnable;
        logic [2:0] outARoute;
        logic [2:0] outBRoute;
        logic outALevelValid;
        logic outBLevelValid;
        logic outAEnable;
        logic outBEnable;
    } cfg_state_s;

endpackage : synth_cfg_pkg

// ---- logic/pump_gain_decode.sv ----
// charge pump gain code to current in unit steps
// assumes a stored 5-bit gain code from the register bank
`timescale 1ns/1ps
module pump_gain_decode (
    input wire logic [4:0] gainCode,
    output logic [4:0] unitCount,
    output logic highImpedance
);
    // ----------------------------------------
    // decode
    // ----------------------------------------
    always_comb
    begin
        unitCount = gainCode;
        highImpedance = (gainCode == 5'h00);
    end
endmodule : pump_gain_decode

// ---- logic/out_route_decode.sv ----
// one output's source, level and powerdown decode
// assumes stored codes; reserved codes give no route at all
`timescale 1ns/1ps
`include "synth_cfg_consts.svh"
module out_route_decode (
    input wire logic [1:0] srcSel,
    input wire logic [5:0] level,
    input wire logic powerdown,
    output logic [2:0] route,
    output logic levelValid,
    output logic enable
);
    // ----------------------------------------
    // decode
    // ----------------------------------------
    always_comb
    begin
        route = 3'h0;
        case (synth_cfg_pkg::src_sel_e'(srcSel))
            synth_cfg_pkg::SRC_OSC: route = 3'h1;
            synth_cfg_pkg::SRC_DIV: route = 3'h2;
            synth_cfg_pkg::SRC_EXT: route = 3'h4;
            default: route = 3'h0;
        endcase
        // reserved levels are held but flagged, the driver may do anything
        levelValid = (level <= `LEVEL_MAX);
        enable = ~powerdown;
    end
endmodule : out_route_decode

// ---- dv/host_model.sv ----
// host side: axi4-lite master moving one word per call
// assumes one caller at a time; released buses show the inverted word
`timescale 1ns/1ps
module host_model (
    input wire logic clk,
    output logic awvalid,
    input wire logic awready,
    output logic [7:0] awaddr,
    output logic wvalid,
    input wire logic wready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    input wire logic bvalid,
    output logic bready,
    output logic arvalid,
    input wire logic arready,
    output logic [7:0] araddr,
    input wire logic rvalid,
    output logic rready
);
    initial
    begin
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr, wdata, wstrb} = 52'h0;
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        {awvalid, wvalid, bready} <= 3'h7;
        forever
        begin
            @(posedge clk);
            if (awready && awvalid)
            begin
                awvalid <= 1'b0;
                awaddr <= ~a;
            end
            if (wready && wvalid)
            begin
                wvalid <= 1'b0;
                wdata <= ~d;
            end
            if (bvalid && bready)
            begin
                bready <= 1'b0;
                break;
            end
        end
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        forever
        begin
            @(posedge clk);
            if (arready && arvalid)
            begin
                arvalid <= 1'b0;
                araddr <= ~a;
            end
            if (rvalid && rready)
            begin
                rready <= 1'b0;
                break;
            end
        end
    endtask : rd
endmodule : host_model

// ---- dv/synth_config_field_decode_tb_top.sv ----
// self-checking bench of the configuration field block
// assumes the host model as bus master and the constants header
`timescale 1ns/1ps
`include "synth_cfg_consts.svh"
module synth_config_field_decode_tb_top;
    localparam logic [31:0] CODE = 32'h0000_3C3C; // arbitrary part code
    logic ref_clk, srst, fastlockEngaged, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, pumpTristate, pumpNegative, refDoublerOn;
    logic integerMode, orderReserved, fracShutdown, outDivInvalid, outDivEnable;
    logic outALevelValid, outBLevelValid, outAEnable, outBEnable, calStart, readbackPartCode;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, v;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, ditherMode, startCore, sa, sb;
    logic [4:0] pumpCurrent, s, f;
    logic [5:0] bleedSetting, outDivRatio, outALevel, outBLevel, la, lb;
    logic [8:0] refDivRatio;
    logic [2:0] modulatorOrder, outARoute, outBRoute;
    logic [11:0] fbDivider;
    logic [21:0] fractionDenominator;
    logic [33:0] expQ[$];
    logic [1:0] bQ[$];
    int errors = 0, checked = 0, cycles = 0, calSeen = 0, nCal = 0, seed = 76;

    synth_config_field_decode #(.PART_CODE(CODE)) DUT (.ref_clk, .srst, .awvalid, .awready,
        .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid,
        .arready, .araddr, .rvalid, .rready, .rdata, .rresp, .fastlockEngaged, .pumpCurrent,
        .pumpTristate, .pumpNegative, .bleedSetting, .refDoublerOn, .refDivRatio,
        .modulatorOrder, .integerMode, .orderReserved, .ditherMode, .fracShutdown,
        .fbDivider, .fractionDenominator, .outDivRatio, .outDivInvalid, .outDivEnable,
        .outARoute, .outBRoute, .outALevel, .outBLevel, .outALevelValid, .outBLevelValid,
        .outAEnable, .outBEnable, .startCore, .calStart, .readbackPartCode);
    host_model HOST (.clk(ref_clk), .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata,
        .wstrb, .bvalid, .bready, .arvalid, .arready, .araddr, .rvalid, .rready);

    initial
    begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    task automatic chk(input string n, input logic [33:0] seen, input logic [33:0] e);
        checked++;
        if (seen !== e)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", n, e, seen);
        end
    endtask : chk

    task automatic end_sim();
        if (errors == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_sim

    task automatic rdx(input logic [7:0] a, input logic [33:0] e);
        expQ.push_back(e);
        HOST.rd(a);
    endtask : rdx

    // decodes land on the edge after the response, so wait one more
    task automatic wrs(input logic [7:0] a, input logic [31:0] d);
        bQ.push_back((a > `OFS_STATUS || a[1:0] != 2'h0) ? `RESP_SLVERR : `RESP_OKAY);
        HOST.wr(a, d);
        @(posedge ref_clk);
    endtask : wrs

    // ----------------------------------------
    // read and write response monitor and hang guard
    // ----------------------------------------
    always @(posedge ref_clk)
    begin
        cycles++;
        if (calStart === 1'b1)
            calSeen++;
        if (rvalid && rready)
            chk("read", {rresp, rdata}, expQ.pop_front());
        if (bvalid && bready)
            chk("wresp", 34'(bresp), 34'(bQ.pop_front()));
        if (cycles == 20000)
        begin
            errors++;
            end_sim();
        end
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        srst = 1'b1;
        fastlockEngaged = 1'b0;
        repeat (10) @(posedge ref_clk);
        srst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        chk("neg", pumpNegative, 1'b1);
        rdx(`OFS_PUMP, {`RESP_OKAY, `RST_PUMP});
        rdx(`OFS_REF, {`RESP_OKAY, `RST_REF});
        rdx(8'h18, {`RESP_SLVERR, 32'h0});
        wrs(8'h18, 32'hFFFF_FFFF);
        wrs(`OFS_STATUS, 32'hFFFF_FFFF);
        for (int k = 0; k < 12; k++)
        begin
            s = (k == 0) ? 5'h00 : 5'($random(seed));
            f = (k == 1) ? 5'h00 : 5'($random(seed));
            la = (s < 5'h04) ? 6'h00 : 6'h02;
            fastlockEngaged <= k[1];
            wrs(`OFS_PUMP, {7'h00, k[0], 2'h0, la, 3'h0, f, 3'h0, s});
            chk("cur", pumpCurrent, k[1] ? f : s);
            chk("tri", pumpTristate, (k[1] ? f : s) == 5'h00);
            chk("neg", pumpNegative, k[0]);
            chk("bleed", bleedSetting, la);
        end
        for (int k = 0; k < 32; k++)
        begin
            {sa, sb, la, lb} = 16'($random(seed));
            v = {2'($random(seed)), lb, 2'h0, la, 4'h0, sb, sa, 3'h0, 5'(k)};
            wrs(`OFS_OUT, v);
            chk("div", outDivRatio, (k < 20) ? 6'(2 * (k + 1)) : 6'h00);
            chk("inv", outDivInvalid, k >= 20);
            chk("rtA", outARoute, (sa == 2'h3) ? 3'h0 : 3'(3'h1 << sa));
            chk("rtB", outBRoute, (sb == 2'h3) ? 3'h0 : 3'(3'h1 << sb));
            chk("lvA", outALevelValid, la <= `LEVEL_MAX);
            chk("lvB", outBLevelValid, lb <= `LEVEL_MAX);
            chk("lA", outALevel, la);
            chk("lB", outBLevel, lb);
            chk("enA", outAEnable, !v[30]);
            chk("enB", outBEnable, !v[31]);
            chk("dEn", outDivEnable, (sa == 2'h1 && !v[30]) || (sb == 2'h1 && !v[31]));
            rdx(`OFS_OUT, {`RESP_OKAY, v});
        end
        for (int k = 0; k < 8; k++)
        begin
            f = 5'(k);
            v[7:0] = (k < 2) ? 8'(k) : (k == 2) ? 8'hFF : 8'($random(seed));
            wrs(`OFS_REF, {14'h0, f[1:0], 7'h0, f[0], v[7:0]});
            chk("ref", refDivRatio, (v[7:0] == 8'h00) ? 9'h100 : {1'b0, v[7:0]});
            chk("dbl", refDoublerOn, f[0]);
            chk("core", startCore, f[1:0]);
        end
        for (int k = 0; k < 16; k++)
        begin
            f = 5'(k);
            v = {10'h0, 22'($random(seed))};
            if (f[2:0] != 3'h0)
            begin
                wrs(`OFS_DENOM, v);
                chk("den", fractionDenominator, v[21:0]);
            end
            // one divider per group of three, so inhibited writes never move the frequency
            v[11:0] = 12'h00E + 12'(37 * (k / 3));
            wrs(`OFS_FREQ_CTRL, {11'h0, k % 3 == 2, 2'h0, f[3:2], 1'b0, f[2:0], v[11:0]});
            nCal += (k % 3 == 2) ? 0 : 1;
            chk("ord", modulatorOrder, f[2:0]);
            chk("int", integerMode, f[2:0] == 3'h0);
            chk("rsv", orderReserved, f[2]);
            chk("dth", ditherMode, f[3:2]);
            chk("shd", fracShutdown, f[3:2] == 2'h3);
            chk("fb", fbDivider, v[11:0]);
            if (f[2:0] == 3'h0)
            begin
                wrs(`OFS_DENOM, 32'h0);
                chk("den", fractionDenominator, 22'h0);
            end
            rdx(`OFS_STATUS, {`RESP_OKAY, 23'h0, k % 3 == 2, nCal[7:0]});
        end
        wrs(`OFS_FREQ_CTRL, 32'h0100_000E);
        chk("idsel", readbackPartCode, 1'b1);
        rdx(`OFS_PUMP, {`RESP_OKAY, CODE});
        rdx(8'h1C, {`RESP_SLVERR, 32'h0});
        wrs(`OFS_FREQ_CTRL, 32'h0000_000E);
        rdx(`OFS_FREQ_CTRL, {`RESP_OKAY, 32'h0000_000E});
        repeat (4) @(posedge ref_clk);
        chk("cal", 34'(calSeen), 34'(nCal + 2));
        chk("left", 34'(expQ.size() + bQ.size()), 34'h0);
        end_sim();
    end
endmodule : synth_config_field_decode_tb_top
